// ==== verilog/csp_supervisor.sv ====
// Purpose: supervisory control of a two-cell series boost charger
// Assumes: comparator and temperature inputs synchronous to clk_sys
// Notes:   AHB-Lite slave, writes zero wait, reads one wait state
// Functional notes
// R01: sys 30mV under battery: switch on, drop held at 24mV.
// R02: presence check on enable, recharge and fault recovery.
// R03: no battery: status blinks 1Hz, host mode sets absent flag.
// R04: battery over 104% opens switch, stops charge, boost tracks.
// R05: balancing on: a cell over 102.5% of half regulation stops charge.
// R06: grounded midpoint disables cell monitoring and balancing.
// R07: pre-charge below threshold times out after 60 minutes.
// R08: fast timer starts on fast entry, selectable or off.
// R09: timer restarts: new cycle, enable rise, select from 00, soft reset.
// R10: thermistor fault freezes charge timer, resumes from held value.
// R11: host-mode watchdog expiry restores defaults, selectable or off.
// R12: host must keep bus activity to service the watchdog.
// R13: hot or cold suspends charging and all timers.
// R14: warm window lowers regulation 120mV per cell.
// R15: cool window halves charge current.
// R16: zones cold, cool, normal, warm, hot split at 0,10,45,60 C.
// R17: die limit 120C above pre-charge, else 60 to 120C by option.
// R18: junction at 150C shuts the boost down.
// R19: input good low with power; status low charging, 1Hz blink on faults.
// R20: status released when complete, disabled or thermal shutdown.
// R21: higher cell discharge on above 50mV mismatch, off below 30mV.
// R22: over-voltage before cells equalize suspends charging.
// R23: 1Hz blink from divided clock, half duty, shared by all.
`include "csp_params.svh"

module csp_supervisor
    import csp_pkg::*;
#(
    parameter int HALF_SEC_CYC = `CSP_HALF_SEC_CYC
) (
    // clock and reset
    input  logic              clk_sys,
    input  logic              rst,
    // ahb-lite slave
    input  logic              hsel,
    input  logic [31:0]       haddr,
    input  logic [1:0]        htrans,
    input  logic              hwrite,
    input  logic [2:0]        hsize,
    input  logic [31:0]       hwdata,
    input  logic              hready,
    output logic              hreadyout,
    output logic              hresp,
    output logic [31:0]       hrdata,
    // mode and power
    input  logic              host_mode,
    input  logic              power_present,
    input  logic              new_cycle,
    input  logic              recharge_req,
    input  logic              term_done,
    // battery comparators
    input  logic              sys_below_batt,
    input  logic              batt_present,
    input  logic              batt_below_pre,
    input  logic              batt_over_volt,
    input  logic              cell_top_over,
    input  logic              cell_bot_over,
    input  logic              mid_grounded,
    input  logic              cell_diff_high,
    input  logic              cell_diff_low,
    input  logic              cell_top_higher,
    // temperatures
    input  logic signed [7:0] batt_temp_c,
    input  logic [7:0]        die_temp_c,
    // power path controls
    output logic              battery_switch_on,
    output logic              supplement_mode,
    output logic [7:0]        switch_drop_mv,
    output logic              sys_track_mode,
    output logic              charge_on,
    output logic              precharge_on,
    output logic [2:0]        battery_regulation_voltage,
    output logic [7:0]        vreg_cell_drop_mv,
    output logic              current_half,
    output logic              die_derate,
    output logic              boost_enable,
    output logic              bal_top_on,
    output logic              bal_bot_on,
    // open-drain indicators
    output logic              input_good_pin_o,
    output logic              input_good_pin_oe,
    output logic              stat_pin_o,
    output logic              stat_pin_oe
);

    localparam int HS_W = 18;

    if (HALF_SEC_CYC < 2 || HALF_SEC_CYC > 2**23) begin : g_chk
        $error("HALF_SEC_CYC out of range");
    end

    function automatic logic [31:0] reg_addr(input logic [2:0] idx);
        reg_addr = {27'h000_0000, idx, 2'b00};
    endfunction

    function automatic logic [HS_W-1:0] min_to_hs(input int mins);
        min_to_hs = HS_W'(mins * 120);
    endfunction

    function automatic logic [HS_W-1:0] sec_to_hs(input int secs);
        sec_to_hs = HS_W'(secs * 2);
    endfunction

    // registers
    logic [7:0]        chg_cfg_r;
    logic [7:0]        tmr_cfg_r;
    logic [7:0]        otp_r;
    logic              otp_lock_r;
    logic              absent_r;
    logic              blink_r;
    logic              bal_active_r;
    logic [22:0]       div_cnt_r;
    logic [HS_W-1:0]   safe_cnt_r;
    logic [HS_W-1:0]   wdt_cnt_r;
    logic              fault_q_r;
    csp_state_t        state_r;
    csp_state_t        state_nxt;

    // bus state
    logic              wr_ph_r;
    logic              rd_ph_r;
    logic [31:0]       addr_q_r;
    logic [31:0]       hrdata_r;

    // bus decode
    wire        accept    = hsel & htrans[1] & hready;
    wire [7:0]  wbyte     = hwdata[7:0];
    wire        wr_chg    = wr_ph_r & (addr_q_r == reg_addr(`CSP_IDX_CHG));
    wire        wr_tmr    = wr_ph_r & (addr_q_r == reg_addr(`CSP_IDX_TMR));
    wire        wr_otp    = wr_ph_r & (addr_q_r == reg_addr(`CSP_IDX_OTP));

    // half-second tick
    wire        half_tick = (div_cnt_r == 23'(HALF_SEC_CYC - 1));

    // temperature classification
    csp_zone_t  zone;
    assign zone = (batt_temp_c <  `CSP_COLD_C) ? ZN_COLD :
                  (batt_temp_c <  `CSP_COOL_C) ? ZN_COOL :
                  (batt_temp_c <= `CSP_WARM_C) ? ZN_NORMAL :
                  (batt_temp_c <= `CSP_HOT_C)  ? ZN_WARM : ZN_HOT;    // [R16]
    wire        ntc_fault = (zone == ZN_COLD) | (zone == ZN_HOT);     // [R13]

    // protection terms
    wire        bal_enabled = ~mid_grounded;                          // [R06]
    wire        cell_ov     = bal_enabled & (cell_top_over | cell_bot_over); // [R05]
    wire        tsd         = (die_temp_c >= `CSP_DIE_SD_C);          // [R18]
    wire        chg_en      = chg_cfg_r[`CSP_CHG_EN_BIT];
    wire        suspend     = batt_over_volt | cell_ov | ntc_fault | absent_r | tsd; // [R22]
    wire        active      = (state_r == ST_PRE) | (state_r == ST_FAST);
    wire        charging    = active & ~suspend;

    // restart and presence-check events
    wire        en_rise     = wr_chg & ~chg_en & wbyte[`CSP_CHG_EN_BIT];
    wire [1:0]  tsel_old    = tmr_cfg_r[`CSP_TMR_SEL_LSB +: 2];
    wire [1:0]  tsel_new    = wbyte[`CSP_TMR_SEL_LSB +: 2];
    wire        tsel_on     = wr_tmr & (tsel_old == 2'b00) & (tsel_new != 2'b00);
    wire        srst        = wr_tmr & wbyte[`CSP_TMR_SRST_BIT];
    wire        start_cyc   = (state_r == ST_IDLE) & (state_nxt != ST_IDLE);
    wire        recharge    = (state_r == ST_DONE) & recharge_req;
    wire        fast_entry  = (state_r == ST_PRE) & (state_nxt == ST_FAST);
    wire        fault_now   = suspend | (state_r == ST_TFAULT);
    wire        recovered   = fault_q_r & ~fault_now;
    wire        tmr_restart = new_cycle | start_cyc | recharge | en_rise
                            | tsel_on | srst | fast_entry;            // [R09] [R08]
    wire        pres_check  = en_rise | recharge | recovered;         // [R02]

    // safety timer limits
    logic [HS_W-1:0] fast_lim;
    assign fast_lim = (tsel_old == 2'b01) ? min_to_hs(`CSP_FAST_T1_MIN) :
                      (tsel_old == 2'b10) ? min_to_hs(`CSP_FAST_T2_MIN) :
                                            min_to_hs(`CSP_FAST_T3_MIN);
    wire        pre_tmo  = (state_r == ST_PRE)
                         & (safe_cnt_r >= min_to_hs(`CSP_PRE_TIMEOUT_MIN)); // [R07]
    wire        fast_tmo = (state_r == ST_FAST) & (tsel_old != 2'b00)
                         & (safe_cnt_r >= fast_lim);                  // [R08]

    // watchdog limits
    wire [1:0]  wsel = tmr_cfg_r[`CSP_WDT_SEL_LSB +: 2];
    logic [HS_W-1:0] wdt_lim;
    assign wdt_lim = (wsel == 2'b01) ? sec_to_hs(`CSP_WDT_T1_S) :
                     (wsel == 2'b10) ? sec_to_hs(`CSP_WDT_T2_S) :
                                       sec_to_hs(`CSP_WDT_T3_S);
    wire        wdt_on    = host_mode & (wsel != 2'b00);              // [R12]
    wire        wdt_fire  = wdt_on & (wdt_cnt_r >= wdt_lim);          // [R11]
    wire        reg_deflt = wdt_fire | srst;

    // die temperature limit
    wire [1:0]  die_sel = otp_r[`CSP_OTP_DIE_LSB +: 2];
    logic [7:0] die_lim;
    assign die_lim = ~batt_below_pre   ? `CSP_DIE_HI_C :
                     (die_sel == 2'b00) ? `CSP_DIE_L0_C :
                     (die_sel == 2'b01) ? `CSP_DIE_L1_C :
                     (die_sel == 2'b10) ? `CSP_DIE_L2_C : `CSP_DIE_HI_C; // [R17]

    // charge state machine
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (chg_en & power_present & ~suspend)
                    state_nxt = batt_below_pre ? ST_PRE : ST_FAST;
            end
            ST_PRE: begin
                if (pre_tmo)
                    state_nxt = ST_TFAULT;
                else if (~batt_below_pre)
                    state_nxt = ST_FAST;
            end
            ST_FAST: begin
                if (fast_tmo)
                    state_nxt = ST_TFAULT;
                else if (term_done & charging)
                    state_nxt = ST_DONE;
            end
            ST_DONE: begin
                if (recharge_req)
                    state_nxt = batt_below_pre ? ST_PRE : ST_FAST;
            end
            ST_TFAULT: begin
                if (new_cycle | en_rise | tsel_on | srst)
                    state_nxt = ST_IDLE;
            end
        endcase
        if (~chg_en | ~power_present | (wr_chg & ~wbyte[`CSP_CHG_EN_BIT]))
            state_nxt = ST_IDLE;
    end

    always_ff @(posedge clk_sys) begin
        if (rst)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // clock divider and blink
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            div_cnt_r <= 23'h00_0000;
            blink_r   <= 1'b0;
        end else if (half_tick) begin
            div_cnt_r <= 23'h00_0000;
            blink_r   <= ~blink_r;                                    // [R23]
        end else begin
            div_cnt_r <= div_cnt_r + 23'h00_0001;
        end
    end

    // safety timer: frozen, not cleared, while suspended
    always_ff @(posedge clk_sys) begin
        if (rst)
            safe_cnt_r <= '0;
        else if (tmr_restart)
            safe_cnt_r <= '0;                                         // [R09]
        else if (charging & half_tick)
            safe_cnt_r <= safe_cnt_r + HS_W'(1);                      // [R10] [R13]
    end

    // watchdog holds in a thermistor fault
    always_ff @(posedge clk_sys) begin
        if (rst)
            wdt_cnt_r <= '0;
        else if (accept | ~wdt_on | wdt_fire)
            wdt_cnt_r <= '0;
        else if (half_tick & ~ntc_fault)
            wdt_cnt_r <= wdt_cnt_r + HS_W'(1);                        // [R13]
    end

    // presence check; found battery clears flag
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            absent_r  <= 1'b0;
            fault_q_r <= 1'b0;
        end else begin
            fault_q_r <= fault_now;
            if (pres_check)
                absent_r <= ~batt_present;                            // [R02]
        end
    end

    // cell balance hysteresis, only while charging
    always_ff @(posedge clk_sys) begin
        if (rst)
            bal_active_r <= 1'b0;
        else if (~bal_enabled | ~charging)
            bal_active_r <= 1'b0;                                     // [R06]
        else if (cell_diff_high)
            bal_active_r <= 1'b1;                                     // [R21]
        else if (cell_diff_low)
            bal_active_r <= 1'b0;                                     // [R21]
    end

    // configuration registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            chg_cfg_r <= `CSP_CHG_RST;
            tmr_cfg_r <= `CSP_TMR_RST;
        end else if (reg_deflt) begin
            chg_cfg_r <= `CSP_CHG_RST;                                // [R11]
            tmr_cfg_r <= `CSP_TMR_RST;
        end else begin
            if (wr_chg)
                chg_cfg_r <= wbyte;
            // soft reset bit never stores
            if (wr_tmr)
                tmr_cfg_r <= wbyte & ~(8'h01 << `CSP_TMR_SRST_BIT);
        end
    end

    // program-once option byte
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            otp_r      <= `CSP_OTP_RST;
            otp_lock_r <= 1'b0;
        end else if (wr_otp & ~otp_lock_r) begin
            otp_r      <= wbyte;
            otp_lock_r <= 1'b1;
        end
    end

    // read mux
    wire [7:0]  stat_byte  = {absent_r, bal_active_r, 1'b0, zone, state_r[1:0]};
    wire [7:0]  fault_byte = {3'b000, tsd, ntc_fault, cell_ov, batt_over_volt,
                              (state_r == ST_TFAULT)};
    logic [7:0] rd_byte;
    assign rd_byte = (addr_q_r == reg_addr(`CSP_IDX_CHG))   ? chg_cfg_r :
                     (addr_q_r == reg_addr(`CSP_IDX_TMR))   ? tmr_cfg_r :
                     (addr_q_r == reg_addr(`CSP_IDX_STAT))  ? stat_byte :
                     (addr_q_r == reg_addr(`CSP_IDX_FAULT)) ? fault_byte :
                     (addr_q_r == reg_addr(`CSP_IDX_OTP))   ? otp_r : 8'h00;

    // reads take one wait so hrdata is a flop
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_ph_r  <= 1'b0;
            rd_ph_r  <= 1'b0;
            addr_q_r <= 32'h0000_0000;
            hrdata_r <= 32'h0000_0000;
        end else begin
            if (rd_ph_r)
                hrdata_r <= {24'h00_0000, rd_byte};
            if (accept) begin
                addr_q_r <= {haddr[31:2], 2'b00};
                wr_ph_r  <= hwrite;
                rd_ph_r  <= ~hwrite;
            end else if (hreadyout) begin
                wr_ph_r  <= 1'b0;
                rd_ph_r  <= 1'b0;
            end else begin
                rd_ph_r  <= 1'b0;
            end
        end
    end

    assign hreadyout = ~rd_ph_r;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    // power path
    assign supplement_mode   = sys_below_batt & ~batt_over_volt;       // [R01]
    assign switch_drop_mv    = supplement_mode ? `CSP_VD_REG_MV : 8'h00; // [R01]
    assign battery_switch_on = ~batt_over_volt & (charging | supplement_mode); // [R04]
    assign sys_track_mode    = batt_over_volt;                         // [R04]
    assign boost_enable      = ~tsd;                                   // [R18]
    assign charge_on         = charging;                               // [R05]
    assign precharge_on      = charging & (state_r == ST_PRE);
    assign battery_regulation_voltage = chg_cfg_r[7:5];
    assign vreg_cell_drop_mv = (zone == ZN_WARM) ? `CSP_WARM_DROP_MV : 8'h00; // [R14]
    assign current_half      = (zone == ZN_COOL);                      // [R15]
    assign die_derate        = (die_temp_c >= die_lim);                // [R17]
    assign bal_top_on        = bal_active_r & cell_top_higher;         // [R21]
    assign bal_bot_on        = bal_active_r & ~cell_top_higher;        // [R21]

    // absent battery blinks only outside host mode
    wire        blink_case = batt_over_volt | cell_ov | ntc_fault
                           | (state_r == ST_TFAULT) | (absent_r & ~host_mode); // [R03]
    assign input_good_pin_o  = 1'b0;
    assign input_good_pin_oe = power_present;                          // [R19]
    assign stat_pin_o        = 1'b0;
    assign stat_pin_oe       = tsd ? 1'b0 :                            // [R20]
                               blink_case ? blink_r :                  // [R19]
                               charging;                               // [R20]

endmodule

// ==== verilog/csp_params.svh ====
// Purpose: constants for the charge supervisor block
// Assumes: 10 MHz system clock, registers one per aligned word
// Notes:   byte address is index times four
`ifndef CSP_PARAMS_SVH
`define CSP_PARAMS_SVH

`define CSP_CLK_KHZ         10_000
`define CSP_BLINK_HALF_MS   500
`define CSP_HALF_SEC_CYC    (`CSP_CLK_KHZ * `CSP_BLINK_HALF_MS)
`define CSP_PRE_TIMEOUT_MIN 60
`define CSP_FAST_T1_MIN     180
`define CSP_FAST_T2_MIN     300
`define CSP_FAST_T3_MIN     600
`define CSP_WDT_T1_S        40
`define CSP_WDT_T2_S        80
`define CSP_WDT_T3_S        160

`define CSP_IDX_CHG         3'd0
`define CSP_IDX_TMR         3'd2
`define CSP_IDX_STAT        3'd3
`define CSP_IDX_FAULT       3'd4
`define CSP_IDX_OTP         3'd5

`define CSP_CHG_EN_BIT      4
`define CSP_TMR_SEL_LSB     1
`define CSP_TMR_SRST_BIT    3
`define CSP_WDT_SEL_LSB     4
`define CSP_OTP_DIE_LSB     3

`define CSP_CHG_RST         8'h38
`define CSP_TMR_RST         8'h95
`define CSP_OTP_RST         8'h18

`define CSP_COLD_C          8'sd0
`define CSP_COOL_C          8'sd10
`define CSP_WARM_C          8'sd45
`define CSP_HOT_C           8'sd60
`define CSP_DIE_SD_C        8'd150
`define CSP_DIE_HI_C        8'd120
`define CSP_DIE_L0_C        8'd60
`define CSP_DIE_L1_C        8'd80
`define CSP_DIE_L2_C        8'd100
`define CSP_VD_REG_MV       8'd24
`define CSP_WARM_DROP_MV    8'd120

`endif

// ==== verilog/csp_pkg.sv ====
// Purpose: types shared by the charge supervisor
// Assumes: nothing
// Notes:   encodings count up from zero in declaration order
package csp_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PRE,
        ST_FAST,
        ST_DONE,
        ST_TFAULT
    } csp_state_t;

    typedef enum logic [2:0] {
        ZN_COLD,
        ZN_COOL,
        ZN_NORMAL,
        ZN_WARM,
        ZN_HOT
    } csp_zone_t;

endpackage

// ==== bench/csp_pack_model.sv ====
// Purpose: behavioural two-cell pack with midpoint sense
// Assumes: cell voltages in mV
// Notes:   comparators settle at once
module csp_pack_model #(
    parameter int CELL_REG_MV = 4200,
    parameter int PRE_MV      = 6000
) (
    // pack state
    input  int   top_mv,
    input  int   bot_mv,
    // comparator outputs
    output logic batt_below_pre,
    output logic batt_over_volt,
    output logic cell_top_over,
    output logic cell_bot_over,
    output logic cell_diff_high,
    output logic cell_diff_low,
    output logic cell_top_higher
);
    timeunit 1ns;
    timeprecision 1ns;
    int diff;
    assign diff            = (top_mv > bot_mv) ? top_mv - bot_mv : bot_mv - top_mv;
    assign batt_below_pre  = (top_mv + bot_mv) < PRE_MV;
    assign batt_over_volt  = (top_mv + bot_mv) * 100 > CELL_REG_MV * 208;
    assign cell_top_over   = top_mv * 1000 > CELL_REG_MV * 1025;
    assign cell_bot_over   = bot_mv * 1000 > CELL_REG_MV * 1025;
    // two thresholds make the hysteresis band
    assign cell_diff_high  = diff > 50;
    assign cell_diff_low   = diff < 30;
    assign cell_top_higher = top_mv > bot_mv;
endmodule

// ==== bench/csp_supervisor_checker.sv ====
// Purpose: port-level checks of the charge supervisor
// Assumes: bound to every csp_supervisor instance
// Notes:   inputs held two cycles before a decision, except the read, supplement, die-limit and boost checks
module csp_supervisor_checker (
    // clock and reset
    input logic              clk_sys,
    input logic              rst,
    // bus
    input logic              hsel,
    input logic [1:0]        htrans,
    input logic              hwrite,
    input logic              hready,
    input logic              hreadyout,
    // sensed inputs
    input logic              batt_over_volt,
    input logic              batt_below_pre,
    input logic              mid_grounded,
    input logic              cell_top_over,
    input logic              cell_bot_over,
    input logic signed [7:0] batt_temp_c,
    input logic [7:0]        die_temp_c,
    // controls
    input logic              supplement_mode,
    input logic              battery_switch_on,
    input logic [7:0]        switch_drop_mv,
    input logic              sys_track_mode,
    input logic              charge_on,
    input logic [7:0]        vreg_cell_drop_mv,
    input logic              die_derate,
    input logic              boost_enable,
    input logic              stat_pin_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_rd_take;
        hsel && htrans[1] && !hwrite && hready;
    endsequence
    sequence s_ntc_fault;
        (batt_temp_c < 8'sh00 || batt_temp_c > 8'sh3c) [*2];
    endsequence
    sequence s_warm;
        (batt_temp_c > 8'sh2d && batt_temp_c <= 8'sh3c) [*2];
    endsequence
    sequence s_cell_ov;
        (!mid_grounded && (cell_top_over || cell_bot_over)) [*2];
    endsequence
    a_read_wait: assert property (s_rd_take |=> !hreadyout ##1 hreadyout)
        else $error("read wait wrong");
    a_supp_drop: assert property (supplement_mode |-> battery_switch_on && switch_drop_mv == 8'h18)
        else $error("supplement drop wrong");
    a_batt_ovp: assert property (batt_over_volt [*2] |-> sys_track_mode && !charge_on)
        else $error("charging in battery ovp");
    a_ntc_stop: assert property (s_ntc_fault |-> !charge_on)
        else $error("charging out of temp window");
    a_warm_drop: assert property (s_warm |-> vreg_cell_drop_mv == 8'h78)
        else $error("warm drop missing");
    a_cell_stop: assert property (s_cell_ov |-> !charge_on)
        else $error("charging with cell over");
    a_die_limit: assert property (!batt_below_pre && die_temp_c >= 8'h78 |-> die_derate)
        else $error("die derate missing");
    a_boost_cut: assert property (boost_enable == (die_temp_c < 8'h96))
        else $error("boost enable wrong");
    a_tsd_release: assert property ((die_temp_c >= 8'h96) [*2] |-> !stat_pin_oe)
        else $error("status driven in shutdown");
    a_stat_charge: assert property (charge_on [*2] |-> stat_pin_oe)
        else $error("status not low charging");
endmodule

bind csp_supervisor csp_supervisor_checker u_chk (.*);

// ==== bench/test_charge_supervisor_protection.sv ====
// Purpose: self-checking bench of the charge supervisor
// Assumes: short half-second tick so timers fit the run
// Notes:   reads note expectations, a negedge monitor compares
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module test_charge_supervisor_protection;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HS = 4;
    typedef struct { logic [7:0] e; logic [7:0] m; } csp_note_t;
    logic hreadyout, hresp, battery_switch_on, supplement_mode, sys_track_mode, charge_on;
    logic precharge_on, current_half, die_derate, boost_enable, bal_top_on, bal_bot_on;
    logic input_good_pin_o, input_good_pin_oe, stat_pin_o, stat_pin_oe, hready;
    logic batt_below_pre, batt_over_volt, cell_top_over, cell_bot_over;
    logic cell_diff_high, cell_diff_low, cell_top_higher;
    logic [31:0]       hrdata;
    logic [7:0]        switch_drop_mv, vreg_cell_drop_mv;
    logic [2:0]        battery_regulation_voltage;
    logic              clk_sys = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0]       haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
    logic [1:0]        htrans = 2'h0;
    logic [2:0]        hsize = 3'h2;
    logic              host_mode = 1'b0, power_present = 1'b1, sys_below_batt = 1'b0;
    logic              batt_present = 1'b1, mid_grounded = 1'b0;
    logic              new_cycle = 1'b0, recharge_req = 1'b0, term_done = 1'b0;
    logic signed [7:0] batt_temp_c = 8'sh19;
    logic [7:0]        die_temp_c = 8'h28;
    int                top_mv = 4000, bot_mv = 4000, error_cnt = 0, checks = 0;
    logic [7:0]        tz [8] = '{8'hff, 8'h00, 8'h09, 8'h0a, 8'h2d, 8'h2e, 8'h3c, 8'h3d};
    logic [2:0]        zc [8] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4};
    int                bt [3] = '{4100, 4040, 4020};
    csp_note_t         notes [$];
    csp_note_t         n;
    logic              rd_dp = 1'b0, ok;
    assign hready = hreadyout;
    csp_supervisor #(.HALF_SEC_CYC(HS)) dut (.*);
    csp_pack_model pack (.*);
    initial forever #50 clk_sys = ~clk_sys;
    task end_sim;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task wait_rdy;
        do begin
            @(negedge clk_sys);
            ok = hreadyout;
            @(posedge clk_sys);
        end while (ok !== 1'b1);
    endtask
    // reads queue a note for the monitor
    task bus(input logic wr, input logic [7:0] a, d, m);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy;
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, d};
        if (!wr) begin
            notes.push_back('{d, m});
            rd_dp = 1'b1;
        end
        wait_rdy;
    endtask
    task wait_chk(input int k);
        repeat (k) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task blink_chk;
        logic s;
        @(negedge clk_sys);
        s = stat_pin_oe;
        repeat (HS) @(negedge clk_sys);
        `CHK("stat_blink", 1'b1, s ^ stat_pin_oe)
        @(posedge clk_sys);
    endtask
    always @(negedge clk_sys) begin
        if (rd_dp && hreadyout === 1'b1) begin
            n = notes.pop_front();
            `CHK("hrdata", {24'h00_0000, n.e}, hrdata & {24'hff_ffff, n.m})
            rd_dp = 1'b0;
        end
    end
    initial begin
        #(45_000 * 100);
        error_cnt++;
        end_sim;
    end
    initial begin
        void'($urandom(48));
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        bus(0, 8'h00, 8'h38, 8'hff);
        bus(0, 8'h08, 8'h95, 8'hff);
        bus(0, 8'h14, 8'h18, 8'hff);
        bus(0, 8'h1c, 8'h00, 8'hff);
        for (int i = 0; i < 8; i++) begin
            batt_temp_c <= tz[i];
            bus(0, 8'h0c, 8'(zc[i]) << 2, 8'h1c);
            wait_chk(1);
            `CHK("cur_half", zc[i] == 3'h1, current_half)
            `CHK("vreg_drop", (zc[i] == 3'h3) ? 8'h78 : 8'h00, vreg_cell_drop_mv)
        end
        batt_temp_c <= 8'sh19;
        wait_chk(8);
        `CHK("charging", 1'b1, charge_on)
        `CHK("stat_low", 1'b1, stat_pin_oe)
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys);
            top_mv <= bt[i];
            wait_chk(4);
            `CHK("bal_top", i < 2, bal_top_on)
        end
        @(posedge clk_sys);
        top_mv <= 2500;
        bot_mv <= 2500;
        bus(1, 8'h00, 8'h28, 8'h00);
        bus(1, 8'h00, 8'h38, 8'h00);
        repeat (1000) @(posedge clk_sys);
        batt_temp_c <= 8'sh46;
        repeat (400) @(posedge clk_sys);
        batt_temp_c <= 8'sh19;
        repeat (7200 * HS - 1200) @(posedge clk_sys);
        // frozen ticks push the timeout out
        bus(0, 8'h10, 8'h00, 8'h01);
        repeat (400) @(posedge clk_sys);
        bus(0, 8'h10, 8'h01, 8'h01);
        blink_chk;
        bus(1, 8'h08, 8'h91, 8'h00);
        bus(1, 8'h08, 8'h95, 8'h00);
        bus(0, 8'h10, 8'h00, 8'h01);
        top_mv <= 4000;
        bot_mv <= 4000;
        batt_present <= 1'b0;
        bus(1, 8'h00, 8'h28, 8'h00);
        wait_chk(2);
        `CHK("stat_off", 1'b0, stat_pin_oe)
        bus(1, 8'h00, 8'h38, 8'h00);
        repeat (8) @(posedge clk_sys);
        blink_chk;
        host_mode <= 1'b1;
        bus(1, 8'h00, 8'h28, 8'h00);
        bus(1, 8'h00, 8'h38, 8'h00);
        bus(0, 8'h0c, 8'h80, 8'h80);
        batt_present <= 1'b1;
        bus(1, 8'h00, 8'h58, 8'h00);
        repeat (80 * HS - 40) @(posedge clk_sys);
        bus(0, 8'h00, 8'h58, 8'hff);
        repeat (80 * HS + 40) @(posedge clk_sys);
        bus(0, 8'h00, 8'h38, 8'hff);
        host_mode <= 1'b0;
        for (int i = 0; i < 24; i++) begin
            @(posedge clk_sys);
            die_temp_c <= 8'($urandom_range(200));
            sys_below_batt <= 1'($urandom);
            mid_grounded <= 1'($urandom);
            power_present <= 1'($urandom);
            top_mv <= 4000 + int'($urandom_range(400));
            bot_mv <= 4000 + int'($urandom_range(800));
            wait_chk(3);
            `CHK("boost", die_temp_c < 8'h96, boost_enable)
            `CHK("derate", die_temp_c >= 8'h78, die_derate)
            `CHK("input_good_pin", power_present, input_good_pin_oe)
        end
        end_sim;
    end
endmodule
